/* hdl/cefl_params.svh */
// Constants of the capture event flag logic: offsets, bit positions, resets.
// Assumes inclusion by bare name from files under hdl/.
`ifndef CEFL_PARAMS_SVH
`define CEFL_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CEFL_OFS_IRQ_ENABLES  8'h2C
`define CEFL_OFS_STATUS_FLAGS 8'h2E
`define CEFL_OFS_FLAG_CLEAR   8'h30
`define CEFL_OFS_FLAG_FORCE   8'h32

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define CEFL_BIT_INT          0
`define CEFL_BIT_CAP1         1
`define CEFL_BIT_CAP4         4
`define CEFL_BIT_WRAP         5
`define CEFL_BIT_PERIOD       6
`define CEFL_BIT_COMPARE      7

// ----------------------------------------
// Reset values and fixed patterns
// ----------------------------------------
`define CEFL_RST_FLAGS        8'h00
`define CEFL_RST_ENABLES      8'h00
`define CEFL_RST_WORD         16'h0000
`define CEFL_CNT_ALL_ONES     32'hFFFFFFFF
`define CEFL_CNT_ZERO         32'h00000000

`endif

/* hdl/cefl_pkg.sv */
// Types of the capture event flag logic.
// Assumes no surroundings beyond the compiler.
`default_nettype none
package cefl_pkg;

   typedef logic [15:0] cefl_word_t;
   typedef logic [7:0]  cefl_addr_t;
   typedef logic [7:0]  cefl_flags_t;
   typedef logic [31:0] cefl_count_t;

   typedef enum logic [2:0] {
      CEFL_SEL_NONE,
      CEFL_SEL_ENABLES,
      CEFL_SEL_FLAGS,
      CEFL_SEL_CLEAR,
      CEFL_SEL_FORCE
   } cefl_sel_t;

endpackage
`default_nettype wire

/* hdl/cefl_event_gen.sv */
// Event detection from the timestamp counter and capture sequencer.
// Assumes counter, compare, period, mode and capture pulses share clk.
`timescale 1ns/1ps
`default_nettype none
`include "cefl_params.svh"

module cefl_event_gen (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Timer state
   input  wire cefl_pkg::cefl_count_t timestamp_counter,
   input  wire cefl_pkg::cefl_count_t asym_pwm_mode_compare_value,
   input  wire cefl_pkg::cefl_count_t asym_pwm_mode_period_value,
   input  wire logic             asym_pwm_mode,
   input  wire logic [3:0]       capture_event_in,
   // Event pulses, bit 0 unused
   output logic [7:0]            event_q
);
   import cefl_pkg::*;

   cefl_count_t prev_q;
   logic [7:0]  event_d;

   // ----------------------------------------
   // Previous counter value
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= `CEFL_CNT_ZERO;
      end else begin
         prev_q <= timestamp_counter;
      end
   end

   // ----------------------------------------
   // Event conditions
   // ----------------------------------------
   always_comb begin
      event_d = 8'h00;
      // Compare reached, asym mode only
      event_d[`CEFL_BIT_COMPARE] = asym_pwm_mode &&
         (timestamp_counter == asym_pwm_mode_compare_value) && (prev_q != asym_pwm_mode_compare_value);
      // Period reached and counter reset
      event_d[`CEFL_BIT_PERIOD] = asym_pwm_mode &&
         (prev_q == asym_pwm_mode_period_value) && (timestamp_counter != asym_pwm_mode_period_value);
      // Rollover in either mode
      event_d[`CEFL_BIT_WRAP] = (prev_q == `CEFL_CNT_ALL_ONES) &&
         (timestamp_counter == `CEFL_CNT_ZERO);
      // Capture events, capture mode only
      event_d[`CEFL_BIT_CAP4:`CEFL_BIT_CAP1] = asym_pwm_mode ? 4'h0 : capture_event_in;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         event_q <= `CEFL_RST_FLAGS;
      end else begin
         event_q <= event_d;
      end
   end

endmodule
`default_nettype wire

/* hdl/cefl_reg_port.sv */
// Register port: address decode and registered read data.
// Assumes a master on clk with one-cycle strobes, never both at once.
`timescale 1ns/1ps
`default_nettype none
`include "cefl_params.svh"

module cefl_reg_port (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Bus side
   input  wire cefl_pkg::cefl_addr_t addr,
   input  wire logic                 rd_stb,
   // Readable state
   input  wire cefl_pkg::cefl_flags_t flags,
   input  wire cefl_pkg::cefl_flags_t enables,
   // Decode and answer
   output cefl_pkg::cefl_sel_t       sel,
   output cefl_pkg::cefl_word_t      rdata_q
);
   import cefl_pkg::*;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      unique case (addr)
         `CEFL_OFS_IRQ_ENABLES:  sel = CEFL_SEL_ENABLES;
         `CEFL_OFS_STATUS_FLAGS: sel = CEFL_SEL_FLAGS;
         `CEFL_OFS_FLAG_CLEAR:   sel = CEFL_SEL_CLEAR;
         `CEFL_OFS_FLAG_FORCE:   sel = CEFL_SEL_FORCE;
         default:                sel = CEFL_SEL_NONE;
      endcase
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= `CEFL_RST_WORD;
      end else if (rd_stb) begin
         unique case (sel)
            CEFL_SEL_ENABLES: rdata_q <= {8'h00, enables[7:1], 1'b0};
            CEFL_SEL_FLAGS:   rdata_q <= {8'h00, flags};
            default:          rdata_q <= `CEFL_RST_WORD;
         endcase
      end else begin
         rdata_q <= `CEFL_RST_WORD;
      end
   end

endmodule
`default_nettype wire

/* hdl/cefl_top.sv */
// Capture event flag logic: sticky event flags, clear, force, global flag.
// Assumes a timer core and capture sequencer on clk, software on the port.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cefl_params.svh"

module cefl_top (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Register port
   input  wire cefl_pkg::cefl_addr_t  addr,
   input  wire cefl_pkg::cefl_word_t  wdata,
   input  wire logic                  wr_stb,
   input  wire logic                  rd_stb,
   output cefl_pkg::cefl_word_t       rdata,
   // Timer core
   input  wire cefl_pkg::cefl_count_t timestamp_counter,
   input  wire cefl_pkg::cefl_count_t asym_pwm_mode_compare_value,
   input  wire cefl_pkg::cefl_count_t asym_pwm_mode_period_value,
   input  wire logic                  asym_pwm_mode,
   input  wire logic [3:0]            capture_event_in,
   // Interrupt
   output logic                       irq_q
);
   import cefl_pkg::*;

   cefl_sel_t   sel;
   cefl_flags_t event_q;
   cefl_flags_t flags_q;
   cefl_flags_t flags_d;
   cefl_flags_t event_irq_enables_q;
   cefl_flags_t clear_mask;
   cefl_flags_t force_mask;
   logic        int_q;
   logic        int_d;
   logic        pending;

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   cefl_event_gen u_event_gen (
      .clk                (clk),
      .resetn             (resetn),
      .timestamp_counter  (timestamp_counter),
      .asym_pwm_mode_compare_value (asym_pwm_mode_compare_value),
      .asym_pwm_mode_period_value  (asym_pwm_mode_period_value),
      .asym_pwm_mode      (asym_pwm_mode),
      .capture_event_in   (capture_event_in),
      .event_q            (event_q)
   );

   cefl_reg_port u_reg_port (
      .clk     (clk),
      .resetn  (resetn),
      .addr    (addr),
      .rd_stb  (rd_stb),
      .flags   (flags_q),
      .enables (event_irq_enables_q),
      .sel     (sel),
      .rdata_q (rdata)
   );

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   always_comb begin
      clear_mask = 8'h00;
      force_mask = 8'h00;
      if (wr_stb && sel == CEFL_SEL_CLEAR) begin
         clear_mask = wdata[7:0];
      end
      if (wr_stb && sel == CEFL_SEL_FORCE) begin
         force_mask = {wdata[7:1], 1'b0};
      end
   end

   // ----------------------------------------
   // Interrupt enables
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         event_irq_enables_q <= `CEFL_RST_ENABLES;
      end else if (wr_stb && sel == CEFL_SEL_ENABLES) begin
         event_irq_enables_q <= {wdata[7:1], 1'b0};
      end
   end

   // ----------------------------------------
   // Event flags
   // ----------------------------------------
   always_comb begin
      flags_d = flags_q;
      for (int i = `CEFL_BIT_CAP1; i <= `CEFL_BIT_COMPARE; i++) begin
         // Set wins over clear, enables not consulted
         flags_d[i] = event_q[i] || force_mask[i] || (flags_q[i] && !clear_mask[i]);
      end
      flags_d[`CEFL_BIT_INT] = int_d;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_q <= `CEFL_RST_FLAGS;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ----------------------------------------
   // Global interrupt flag and output
   // ----------------------------------------
   assign pending = |(flags_q[7:1] & event_irq_enables_q[7:1]);
   assign int_q   = flags_q[`CEFL_BIT_INT];

   always_comb begin
      // New request only while global flag clear
      int_d = (!int_q && pending) || (int_q && !clear_mask[`CEFL_BIT_INT]);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= int_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_flag_read;
      rd_stb && sel == CEFL_SEL_FLAGS |=> rdata == {8'h00, $past(flags_q)};
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag register read data wrong");

   property p_compare_mode;
      $rose(flags_q[`CEFL_BIT_COMPARE]) |->
         $past(asym_pwm_mode, 2) || $past(force_mask[`CEFL_BIT_COMPARE]);
   endproperty
   a_compare_mode: assert property (p_compare_mode)
      else $error("compare flag set outside asym mode");

   property p_period_set;
      $past(resetn) && asym_pwm_mode && timestamp_counter != asym_pwm_mode_period_value &&
         $past(timestamp_counter) == asym_pwm_mode_period_value |-> ##2 flags_q[`CEFL_BIT_PERIOD];
   endproperty
   a_period_set: assert property (p_period_set)
      else $error("period flag not set");

   property p_wrap_set;
      $past(resetn) && timestamp_counter == `CEFL_CNT_ZERO &&
         $past(timestamp_counter) == `CEFL_CNT_ALL_ONES |-> ##2 flags_q[`CEFL_BIT_WRAP];
   endproperty
   a_wrap_set: assert property (p_wrap_set)
      else $error("wrap flag not set after rollover");

   property p_capture_set;
      !asym_pwm_mode && capture_event_in[0] |-> ##2 flags_q[`CEFL_BIT_CAP1];
   endproperty
   a_capture_set: assert property (p_capture_set)
      else $error("capture event one not latched");

   property p_int_raise;
      !int_q && pending |=> int_q && irq_q;
   endproperty
   a_int_raise: assert property (p_int_raise)
      else $error("global flag not raised on request");

   property p_clear_four;
      wr_stb && sel == CEFL_SEL_CLEAR && wdata[`CEFL_BIT_CAP4] && !event_q[`CEFL_BIT_CAP4]
         |=> !flags_q[`CEFL_BIT_CAP4];
   endproperty
   a_clear_four: assert property (p_clear_four)
      else $error("clear of event four failed");

   property p_rearm;
      wr_stb && sel == CEFL_SEL_CLEAR && wdata[7:0] == 8'h01 && int_q && pending
         |=> !int_q ##1 int_q;
   endproperty
   a_rearm: assert property (p_rearm)
      else $error("pending request not reissued");

   property p_force_int_ignored;
      wr_stb && sel == CEFL_SEL_FORCE && wdata[7:0] == 8'h01 && !int_q && !pending
         |=> !int_q;
   endproperty
   a_force_int_ignored: assert property (p_force_int_ignored)
      else $error("force bit 0 changed global flag");

   property p_latch_masked;
      event_q[`CEFL_BIT_WRAP] && !event_irq_enables_q[`CEFL_BIT_WRAP]
         |=> flags_q[`CEFL_BIT_WRAP];
   endproperty
   a_latch_masked: assert property (p_latch_masked)
      else $error("masked event not latched");

   property p_set_wins;
      |(event_q[7:1] & clear_mask[7:1])
         |=> (flags_q[7:1] & $past(event_q[7:1])) == $past(event_q[7:1]);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a same-cycle set");

   property p_compare_set;
      $past(resetn) && asym_pwm_mode && timestamp_counter == asym_pwm_mode_compare_value &&
         $past(timestamp_counter) != asym_pwm_mode_compare_value |-> ##2 flags_q[`CEFL_BIT_COMPARE];
   endproperty
   a_compare_set: assert property (p_compare_set)
      else $error("compare flag not set");

   property p_period_mode;
      $rose(flags_q[`CEFL_BIT_PERIOD]) |->
         $past(asym_pwm_mode, 2) || $past(force_mask[`CEFL_BIT_PERIOD]);
   endproperty
   a_period_mode: assert property (p_period_mode)
      else $error("period flag set outside asym mode");

   property p_wrap_cause;
      $rose(flags_q[`CEFL_BIT_WRAP]) |-> $past(force_mask[`CEFL_BIT_WRAP]) ||
         ($past(timestamp_counter, 2) == `CEFL_CNT_ZERO &&
          $past(timestamp_counter, 3) == `CEFL_CNT_ALL_ONES);
   endproperty
   a_wrap_cause: assert property (p_wrap_cause)
      else $error("wrap flag set without rollover");

   property p_capture_mode;
      $rose(flags_q[`CEFL_BIT_CAP1]) |->
         !$past(asym_pwm_mode, 2) || $past(force_mask[`CEFL_BIT_CAP1]);
   endproperty
   a_capture_mode: assert property (p_capture_mode)
      else $error("capture flag set in asym mode");

   property p_int_hold;
      int_q && !clear_mask[`CEFL_BIT_INT] |=> int_q;
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("global flag dropped without clear");

   property p_int_cause;
      $rose(int_q) |-> $past(pending);
   endproperty
   a_int_cause: assert property (p_int_cause)
      else $error("global flag raised without request");

   property p_irq_flag;
      irq_q == int_q;
   endproperty
   a_irq_flag: assert property (p_irq_flag)
      else $error("interrupt output differs from global flag");

   property p_clear_bits;
      wr_stb && sel == CEFL_SEL_CLEAR |=>
         (flags_q[7:1] & $past(wdata[7:1]) & ~$past(event_q[7:1])) == 7'h00;
   endproperty
   a_clear_bits: assert property (p_clear_bits)
      else $error("clear write left a flag set");

   property p_cmd_read_zero;
      rd_stb && (sel == CEFL_SEL_CLEAR || sel == CEFL_SEL_FORCE) |=> rdata == `CEFL_RST_WORD;
   endproperty
   a_cmd_read_zero: assert property (p_cmd_read_zero)
      else $error("command register read not zero");

   property p_force_bits;
      wr_stb && sel == CEFL_SEL_FORCE |=>
         (flags_q[7:1] & $past(wdata[7:1])) == $past(wdata[7:1]);
   endproperty
   a_force_bits: assert property (p_force_bits)
      else $error("force write did not set a flag");

   property p_no_request;
      !int_q && !pending |=> !int_q;
   endproperty
   a_no_request: assert property (p_no_request)
      else $error("request raised with no enabled flag");

   property p_flags_hold;
      !(wr_stb && sel == CEFL_SEL_CLEAR) |=>
         (flags_q[7:1] & $past(flags_q[7:1])) == $past(flags_q[7:1]);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("flag dropped without clear");

   property p_upper_zero;
      rdata[15:8] == 8'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read byte not zero");

   c_irq_rise:      cover property (!irq_q ##1 irq_q);
   c_rearm:         cover property (int_q && clear_mask[0] && pending ##1 !int_q ##1 int_q);
   c_force_capture: cover property (force_mask[`CEFL_BIT_CAP4] ##1 flags_q[`CEFL_BIT_CAP4]);
   c_set_wins:      cover property (|(event_q[7:1] & clear_mask[7:1]));

endmodule
`default_nettype wire

/* tb/cefl_irq_sink.sv */
// Interrupt controller model: counts rising edges of the interrupt line.
// Assumes a level interrupt synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module cefl_irq_sink (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Interrupt line
   input  wire logic irq,
   output var  int   n_raised
);
   logic irq_seen_q;

   // ----------------------------------------
   // Edge counting
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_seen_q <= 1'b0;
         n_raised   <= 0;
      end else begin
         irq_seen_q <= irq;
         if (irq && !irq_seen_q) begin
            n_raised <= n_raised + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/cefl_top_tb.sv */
// Self-checking bench of the capture event flag logic.
// Assumes the design under hdl/ and the interrupt model under tb/.
`timescale 1ns/1ps
`default_nettype none
`include "cefl_params.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module cefl_top_tb;
   import cefl_pkg::*;

   localparam cefl_addr_t A_ENA = `CEFL_OFS_IRQ_ENABLES;
   localparam cefl_addr_t A_FLG = `CEFL_OFS_STATUS_FLAGS;
   localparam cefl_addr_t A_CLR = `CEFL_OFS_FLAG_CLEAR;
   localparam cefl_addr_t A_FRC = `CEFL_OFS_FLAG_FORCE;

   logic        clk               = 1'b0;
   logic        resetn            = 1'b0;
   logic        wr_stb            = 1'b0;
   logic        rd_stb            = 1'b0;
   logic        asym_pwm_mode     = 1'b0;
   logic [3:0]  capture_event_in  = 4'h0;
   cefl_addr_t  addr              = 8'h00;
   cefl_word_t  wdata             = 16'h0000;
   cefl_word_t  rdata;
   cefl_count_t timestamp_counter = 32'h00000005;
   cefl_count_t cmp_val           = 32'h0000000A;
   cefl_count_t prd_val           = 32'h00000014;
   cefl_count_t cnt_seq [6]       = '{32'h9, 32'hA, 32'h14, 32'h0, 32'hFFFFFFFF, 32'h0};
   logic        irq_q;
   int          n_fail            = 0;
   int          comparisons       = 0;
   int          n_raised;

   always #25 clk = ~clk;

   cefl_top i_cefl_top (
      .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .timestamp_counter(timestamp_counter),
      .asym_pwm_mode_compare_value(cmp_val), .asym_pwm_mode_period_value(prd_val),
      .asym_pwm_mode(asym_pwm_mode), .capture_event_in(capture_event_in), .irq_q(irq_q)
   );

   cefl_irq_sink i_cefl_irq_sink (
      .clk(clk), .resetn(resetn), .irq(irq_q), .n_raised(n_raised)
   );

   // ----------------------------------------
   // Register port and event drivers
   // ----------------------------------------
   task automatic wr(input cefl_addr_t a, input cefl_word_t d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input cefl_addr_t a, input cefl_word_t exp, input string nm);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      `CHK(nm, exp, rdata)
   endtask

   task automatic run_events;
      foreach (cnt_seq[k]) begin
         @(posedge clk);
         timestamp_counter <= cnt_seq[k];
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         capture_event_in <= 4'h1 << i;
      end
      @(posedge clk);
      capture_event_in <= 4'h0;
      repeat (3) @(posedge clk);
   endtask

   task automatic complete_run;
      $display("counts: %0d checks, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rd(A_FLG, 16'h0000, "flags reset");
      rd(A_ENA, 16'h0000, "enables reset");
      rd(A_CLR, 16'h0000, "clear reads");
      wr(A_FLG, 16'hFFFF);
      rd(8'h40, 16'h0000, "unmapped");
      rd(A_FLG, 16'h0000, "flags read only");
      $display("test reset done");
      wr(A_FRC, 16'hFFFF);
      rd(A_FRC, 16'h0000, "force reads");
      rd(A_FLG, 16'h00FE, "forced flags");
      `CHK("irq masked", 1'b0, irq_q)
      wr(A_CLR, 16'h0000);
      rd(A_FLG, 16'h00FE, "zero clear");
      for (int i = 1; i < 8; i++) begin
         wr(A_CLR, 16'h0001 << i);
         rd(A_FLG, (16'h00FE << i) & 16'h00FE, "clear bit");
      end
      $display("test force and clear done");
      @(posedge clk);
      asym_pwm_mode <= 1'b1;
      run_events();
      rd(A_FLG, 16'h00E0, "asym events");
      wr(A_CLR, 16'h00FE);
      @(posedge clk);
      asym_pwm_mode <= 1'b0;
      run_events();
      rd(A_FLG, 16'h003E, "capture events");
      @(posedge clk);
      timestamp_counter <= 32'hFFFFFFFF;
      @(posedge clk);
      timestamp_counter <= 32'h00000000;
      wr(A_CLR, 16'h0020);
      rd(A_FLG, 16'h003E, "set over clear");
      $display("test events done");
      wr(A_CLR, 16'h00FF);
      wr(A_ENA, 16'h0002);
      rd(A_ENA, 16'h0002, "enables");
      wr(A_FRC, 16'h0006);
      repeat (2) @(posedge clk);
      rd(A_FLG, 16'h0007, "global flag");
      `CHK("irq raised", 1'b1, irq_q)
      wr(A_CLR, 16'h0001);
      #1;
      `CHK("irq cleared", 1'b0, irq_q)
      @(posedge clk);
      #1;
      `CHK("irq rearmed", 1'b1, irq_q)
      wr(A_CLR, 16'h0003);
      wr(A_FRC, 16'h0001);
      repeat (3) @(posedge clk);
      rd(A_FLG, 16'h0004, "no force of global");
      `CHK("irq idle", 1'b0, irq_q)
      `CHK("irq edges", 2, n_raised)
      wr(A_FRC, 16'h0002);
      repeat (2) @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(A_FLG, 16'h0000, "flags second reset");
      rd(A_ENA, 16'h0000, "enables second reset");
      `CHK("irq second reset", 1'b0, irq_q)
      $display("test interrupt done");
      complete_run();
   end

   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
